// ===== design/vkpc_params.svh
// Purpose : constants for the video keyer and pattern control block
// Assumes : 8-bit video samples, 25 MHz clock
// Notes   : definitions only
`ifndef VKPC_PARAMS_SVH
`define VKPC_PARAMS_SVH
`define VKPC_PIX_MAX      8'hFF
`define VKPC_LEGAL_LO     8'h10
`define VKPC_LEGAL_HI     8'hEB
`define VKPC_CHROMA_MAX   8'hC0
`define VKPC_CENTER_X     8'h80
`define VKPC_CENTER_Y     8'h80
`define VKPC_SURR_MIN     6'h01
`define VKPC_SURR_MAX     6'h03
`define VKPC_SHAD_H_MIN   6'h01
`define VKPC_SHAD_H_MAX   6'h06
`define VKPC_SHAD_W_MIN   6'h01
`define VKPC_SHAD_W_MAX   6'h3C
`define VKPC_NUM_PATTERNS 10
`define VKPC_NUM_SLOTS    4
`define VKPC_NUM_XPT      16
`endif

// ===== design/vkpc_pkg.sv
// Purpose : shared types of the keyer and pattern control block
// Assumes : nothing
// Notes   : edge modes are binary-coded values 0 to 4 by construction of the enum
`default_nettype none
package vkpc_pkg;
  typedef enum logic [2:0] {
    VKPC_EDGE_NONE     = 3'b000,
    VKPC_EDGE_SURROUND = 3'b001,
    VKPC_EDGE_SHADOW   = 3'b010,
    VKPC_EDGE_EXTRUDE  = 3'b011,
    VKPC_EDGE_OUTLINE  = 3'b100
  } vkpc_edge_t;
endpackage
`default_nettype wire

// ===== design/vkpc_buf2.sv
// Purpose : two-entry valid/ready buffer in the pixel path
// Assumes : single clock, async active-low reset
// Notes   : full throughput; ready depends only on occupancy
`default_nettype none
module vkpc_buf2 #(
  parameter int W = 8
) (
  input  wire logic         i_clk,     // clock
  input  wire logic         i_rst_n,   // async reset
  input  wire logic         i_valid,   // write valid
  output logic              o_ready,   // space available
  input  wire logic [W-1:0] i_data,    // write data
  output logic              o_valid,   // read valid
  input  wire logic         i_ready,   // reader accepts
  output logic [W-1:0]      o_data     // read data
);
  logic [W-1:0] mem [2];
  logic         wp;
  logic         rp;
  logic [1:0]   cnt;
  wire          wr = i_valid && o_ready;
  wire          rd = o_valid && i_ready;

  assign o_ready = (cnt != 2'h2);
  assign o_valid = (cnt != 2'h0);
  assign o_data  = mem[rp];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (wr) wp <= ~wp;
      if (rd) rp <= ~rp;
      cnt <= cnt + {1'b0, wr} - {1'b0, rd};
    end
  end

  always_ff @(posedge i_clk) begin
    if (wr) mem[wp] <= i_data;
  end
endmodule
`default_nettype wire

// ===== design/vkpc_clamp.sv
// Purpose : clamp a line count into a legal range
// Assumes : combinational helper
// Notes   : used for each edge-effect dimension
`default_nettype none
module vkpc_clamp (
  input  wire logic [5:0] i_val,   // requested count
  input  wire logic [5:0] i_min,   // least legal
  input  wire logic [5:0] i_max,   // most legal
  output logic      [5:0] o_val    // clamped count
);
  always_comb begin
    if (i_val < i_min)      o_val = i_min;
    else if (i_val > i_max) o_val = i_max;
    else                    o_val = i_val;
  end
endmodule
`default_nettype wire

// ===== design/vkpc_keyer.sv
// Purpose : one keyer with its pattern generator controls
// Assumes : panel buttons are one-cycle pulses on i_clk; knobs are levels
// Notes   : pixels pass a two-entry buffer so a stalled sink loses none
`include "vkpc_params.svh"
`default_nettype none
module vkpc_keyer #(
  parameter int NXPT = `VKPC_NUM_XPT
) (
  input  wire logic       i_clk,              // 25 MHz clock
  input  wire logic       i_rst_n,            // async reset, active low
  input  wire logic       i_show_white_press, // white-fill view toggle
  input  wire logic [7:0] i_opacity,          // key translucence knob
  input  wire logic [7:0] i_clip,             // clip / fg threshold
  input  wire logic [7:0] i_gain,             // gain / bg threshold
  input  wire logic       i_split_mode,       // split threshold mode
  input  wire logic [2:0] i_edge_sel,         // requested edge mode
  input  wire logic       i_edge_sel_strobe,  // take edge mode
  input  wire logic [5:0] i_edge_h,           // edge height lines
  input  wire logic [5:0] i_edge_w,           // edge width lines
  input  wire logic       i_shadow_left,      // shadow side select; no logic reads it
  input  wire logic       i_key_mem_en,       // key memory enable
  input  wire logic [3:0] i_xpt,              // key-bus crosspoint
  input  wire logic       i_xpt_strobe,       // crosspoint selected
  input  wire logic [7:0] i_matte_hue,        // matte hue
  input  wire logic [7:0] i_matte_saturation, // matte saturation
  input  wire logic [7:0] i_matte_brightness, // matte brightness
  input  wire logic [7:0] i_matte_opacity,    // matte translucence
  input  wire logic       i_legal_range,      // clamp matte to legal
  input  wire logic [9:0] i_pattern_press,    // pattern buttons
  input  wire logic       i_store_press,      // pattern store command
  input  wire logic [3:0] i_slot_press,       // slot buttons
  input  wire logic       i_undo_press,       // undo
  input  wire logic       i_other_press,      // any other button
  input  wire logic       i_pos_toggle,       // positioner on/off
  input  wire logic       i_center_press,     // centre pattern
  input  wire logic signed [7:0] i_move_x,    // positioner delta x
  input  wire logic signed [7:0] i_move_y,    // positioner delta y
  input  wire logic       i_dir_normal,       // normal direction
  input  wire logic       i_dir_reverse,      // reverse direction
  input  wire logic       i_alt_toggle,       // alternating on/off
  input  wire logic       i_wipe_done,        // a wipe finished
  input  wire logic       i_border_toggle,    // pattern border
  input  wire logic [7:0] i_border_width,     // border width knob
  input  wire logic       i_soft_toggle,      // edge diffusion
  input  wire logic [7:0] i_softness,         // softness knob
  input  wire logic       i_edge_balance_enable, // symmetry enable
  input  wire logic [7:0] i_symmetry,         // symmetry knob
  input  wire logic       i_polarity_toggle,  // region polarity
  input  wire logic       i_pix_valid,        // pixel in valid
  output logic            o_pix_ready,        // pixel in ready
  input  wire logic [7:0] i_key_luma,         // key source luma
  input  wire logic [7:0] i_fill,             // fill pixel
  input  wire logic [7:0] i_bkgd,             // background pixel
  input  wire logic       i_pat_white,        // pattern white region
  input  wire logic       i_edge_px,          // pixel in edge band
  output logic            o_pix_valid,        // pixel out valid
  input  wire logic       i_pix_ready,        // sink ready
  output logic [7:0]      o_pix,              // keyed pixel
  output logic            o_show_white,       // white view active
  output logic [2:0]      o_edge_mode,        // active edge mode
  output logic [5:0]      o_edge_h_eff,       // clamped height
  output logic [5:0]      o_edge_w_eff,       // clamped width
  output logic [9:0]      o_pattern_sel,      // lit pattern
  output logic [7:0]      o_pos_x,            // pattern x
  output logic [7:0]      o_pos_y,            // pattern y
  output logic            o_pos_en,           // positioner on
  output logic            o_wipe_reverse,     // next wipe reversed
  output logic [7:0]      o_border_w_eff,     // border width used
  output logic [7:0]      o_soft_eff,         // softness used
  output logic [7:0]      o_edge_balance_enable_eff,         // symmetry used
  output logic [7:0]      o_matte_y,          // matte luma
  output logic [7:0]      o_matte_c,          // matte chroma
  output logic [7:0]      o_matte_alpha       // matte opacity
);
  // pattern setup word: pattern, border, soft, edge_balance_enable, polarity, dir
  localparam int PW = 15;
  logic             show_white;
  vkpc_pkg::vkpc_edge_t edge_mode;
  logic [5:0]       edge_h;
  logic [5:0]       edge_w;
  logic [9:0]       pat_sel;
  logic             border_en;
  logic             soft_en;
  logic             edge_balance_enable_en;
  logic             polarity;
  logic             dir_rev;
  logic             alt_en;
  logic             alt_phase;
  logic             store_armed;
  logic             undo_ok;
  logic [PW-1:0]    undo_word;
  logic [PW-1:0]    slot_mem [`VKPC_NUM_SLOTS];
  logic [18:0]      key_mem [NXPT];
  logic [3:0]       cur_xpt;
  logic             pos_en;
  logic [7:0]       last_x;
  logic [7:0]       last_y;
  logic [PW-1:0]    cur_word;
  logic [PW-1:0]    next_word;
  logic             next_load;
  logic [1:0]       slot_idx;
  logic [5:0]       h_cl;
  logic [5:0]       w_cl;
  logic [5:0]       hmin;
  logic [5:0]       hmax;
  logic [5:0]       wmax;

  assign cur_word = {pat_sel, border_en, soft_en, edge_balance_enable_en, polarity,
                     dir_rev};

  always_comb begin
    slot_idx = 2'h0;
    for (int i = `VKPC_NUM_SLOTS - 1; i >= 0; i--) begin
      if (i_slot_press[i]) slot_idx = 2'(i);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) show_white <= 1'b0;
    else if (i_show_white_press) show_white <= ~show_white;
  end

  // edge mode, edge sizes and crosspoint select share one process; key memory is written in its own
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      edge_mode <= vkpc_pkg::VKPC_EDGE_NONE;
      edge_h    <= `VKPC_SHAD_H_MIN;
      edge_w    <= `VKPC_SHAD_W_MIN;
      cur_xpt   <= 4'h0;
    end else if (i_xpt_strobe) begin
      cur_xpt <= i_xpt;
      if (i_key_mem_en) begin
        edge_mode <= vkpc_pkg::vkpc_edge_t'(key_mem[i_xpt][2:0]);
        edge_h    <= key_mem[i_xpt][8:3];
        edge_w    <= key_mem[i_xpt][14:9];
      end
    end else begin
      if (i_edge_sel_strobe && i_edge_sel <= 3'h4)
        edge_mode <= vkpc_pkg::vkpc_edge_t'(i_edge_sel);
      edge_h <= h_cl;
      edge_w <= w_cl;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_key_mem_en && !i_xpt_strobe)
      key_mem[cur_xpt] <= {4'h0, edge_w, edge_h, edge_mode};
  end

  always_comb begin
    hmin = `VKPC_SHAD_H_MIN;
    hmax = `VKPC_SHAD_H_MAX;
    wmax = `VKPC_SHAD_W_MAX;
    if (edge_mode == vkpc_pkg::VKPC_EDGE_SURROUND ||
        edge_mode == vkpc_pkg::VKPC_EDGE_OUTLINE) begin
      hmin = `VKPC_SURR_MIN;
      hmax = `VKPC_SURR_MAX;
      wmax = `VKPC_SURR_MAX;
    end
  end

  vkpc_clamp u_clamp_h (
    .i_val (i_edge_h),
    .i_min (hmin),
    .i_max (hmax),
    .o_val (h_cl)
  );
  vkpc_clamp u_clamp_w (
    .i_val (i_edge_w),
    .i_min (`VKPC_SHAD_W_MIN),
    .i_max (wmax),
    .o_val (w_cl)
  );

  // pattern setup: radio group, slots, undo, modifiers
  always_comb begin
    next_load = 1'b0;
    next_word = cur_word;
    if (i_undo_press && undo_ok) begin
      next_load = 1'b1;
      next_word = undo_word;
    end else if (|i_slot_press && !store_armed) begin
      next_load = 1'b1;
      next_word = slot_mem[slot_idx];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pat_sel   <= 10'h001;
      border_en <= 1'b0;
      soft_en   <= 1'b0;
      edge_balance_enable_en   <= 1'b0;
      polarity  <= 1'b0;
      dir_rev   <= 1'b0;
    end else if (next_load) begin
      {pat_sel, border_en, soft_en, edge_balance_enable_en, polarity, dir_rev} <= next_word;
    end else begin
      for (int i = `VKPC_NUM_PATTERNS - 1; i >= 0; i--) begin
        if (i_pattern_press[i]) pat_sel <= 10'h001 << i;
      end
      if (i_border_toggle) border_en <= ~border_en;
      if (i_soft_toggle) soft_en <= ~soft_en;
      if (i_edge_balance_enable) edge_balance_enable_en <= ~edge_balance_enable_en;
      if (i_polarity_toggle) polarity <= ~polarity;
      if (i_dir_normal) dir_rev <= 1'b0;
      else if (i_dir_reverse) dir_rev <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      store_armed <= 1'b0;
      undo_ok     <= 1'b0;
      undo_word   <= '0;
    end else begin
      if (i_store_press) store_armed <= 1'b1;
      else if (|i_slot_press || i_other_press) store_armed <= 1'b0;
      if (|i_slot_press && (store_armed || !i_undo_press)) begin
        undo_ok   <= 1'b1;
        undo_word <= cur_word;
      end else if (i_undo_press || i_other_press || i_store_press ||
                   |i_pattern_press) begin
        undo_ok <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (|i_slot_press && store_armed)
      slot_mem[slot_idx] <= cur_word;
  end

  // wipe direction with alternating phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alt_en    <= 1'b0;
      alt_phase <= 1'b0;
    end else begin
      if (i_alt_toggle) begin
        alt_en    <= ~alt_en;
        alt_phase <= 1'b0;
      end else if (i_dir_normal || i_dir_reverse) begin
        alt_phase <= 1'b0;
      end else if (i_wipe_done && alt_en) begin
        alt_phase <= ~alt_phase;
      end
    end
  end

  // positioner
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos_en <= 1'b0;
      last_x <= `VKPC_CENTER_X;
      last_y <= `VKPC_CENTER_Y;
    end else begin
      if (i_pos_toggle) pos_en <= ~pos_en;
      if (i_center_press) begin
        last_x <= `VKPC_CENTER_X;
        last_y <= `VKPC_CENTER_Y;
      end else if (pos_en) begin
        last_x <= last_x + i_move_x;
        last_y <= last_y + i_move_y;
      end
    end
  end

  // key computation
  logic [7:0]  key_raw;
  logic [8:0]  d;
  logic [15:0] gk;
  logic [7:0]  key_lin;
  logic [15:0] k_scaled;
  logic [7:0]  k_eff;
  logic [7:0]  fill_v;
  logic [7:0]  lm;
  logic [15:0] blend;
  logic        in_region;
  logic [7:0]  matte_c_raw;

  always_comb begin
    d      = {1'b0, i_key_luma} - {1'b0, i_clip};
    gk     = 16'h0000;
    if (i_split_mode) begin
      if (i_key_luma > i_clip) key_raw = `VKPC_PIX_MAX;
      else if (i_key_luma < i_gain) key_raw = 8'h00;
      else key_raw = 8'(({8'h00, i_key_luma - i_gain} << 8) /
                      {7'h00, {1'b0, i_clip - i_gain} + 9'h001});
    end else if (d[8] || d == 9'h000) begin
      key_raw = 8'h00;
    end else begin
      gk = d[7:0] * ({8'h00, i_gain} + 16'h0001);
      key_raw = (gk[15:4] > 12'h0FF) ? `VKPC_PIX_MAX : gk[11:4];
    end
    in_region = polarity ? !i_pat_white : i_pat_white;
    key_lin = key_raw;
    unique case (edge_mode)
      vkpc_pkg::VKPC_EDGE_OUTLINE: key_lin = i_edge_px ? 8'hFF : 8'h00;
      default: if (i_edge_px && edge_mode != vkpc_pkg::VKPC_EDGE_NONE)
                 key_lin = `VKPC_PIX_MAX;
    endcase
    // adding key_lin once lets a full-clockwise knob pass the key unscaled
    k_scaled = key_lin * i_opacity + {8'h00, key_lin};
    k_eff    = in_region ? k_scaled[15:8] : 8'h00;
    fill_v   = show_white ? `VKPC_PIX_MAX :
               ((i_edge_px && edge_mode != vkpc_pkg::VKPC_EDGE_NONE) ?
                o_matte_y : i_fill);
    // weights sum to 256 so a zero key passes background exactly
    blend = fill_v * k_eff + i_bkgd * (8'hFF - k_eff) +
            {8'h00, i_bkgd};
    matte_c_raw = i_matte_saturation ^ i_matte_hue;
    lm = i_matte_brightness;
    if (i_legal_range) begin
      if (lm < `VKPC_LEGAL_LO) lm = `VKPC_LEGAL_LO;
      else if (lm > `VKPC_LEGAL_HI) lm = `VKPC_LEGAL_HI;
    end
  end

  vkpc_buf2 #(.W(8)) u_buf (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (i_pix_valid),
    .o_ready (o_pix_ready),
    .i_data  (blend[15:8]),
    .o_valid (o_pix_valid),
    .i_ready (i_pix_ready),
    .o_data  (o_pix)
  );

  // registered status outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_show_white   <= 1'b0;
      o_edge_mode    <= 3'h0;
      o_edge_h_eff   <= 6'h00;
      o_edge_w_eff   <= 6'h00;
      o_pattern_sel  <= 10'h001;
      o_pos_x        <= `VKPC_CENTER_X;
      o_pos_y        <= `VKPC_CENTER_Y;
      o_pos_en       <= 1'b0;
      o_wipe_reverse <= 1'b0;
      o_border_w_eff <= 8'h00;
      o_soft_eff     <= 8'h00;
      o_edge_balance_enable_eff     <= 8'h80;
      o_matte_y      <= 8'h00;
      o_matte_c      <= 8'h00;
      o_matte_alpha  <= 8'h00;
    end else begin
      o_show_white   <= show_white;
      o_edge_mode    <= edge_mode;
      o_edge_h_eff   <= edge_h;
      o_edge_w_eff   <= edge_w;
      o_pattern_sel  <= pat_sel;
      o_pos_x        <= last_x;
      o_pos_y        <= last_y;
      o_pos_en       <= pos_en;
      o_wipe_reverse <= dir_rev ^ (alt_en & alt_phase);
      o_border_w_eff <= border_en ? i_border_width : 8'h00;
      o_soft_eff     <= soft_en ? i_softness : 8'h00;
      o_edge_balance_enable_eff     <= (soft_en && edge_balance_enable_en) ? i_symmetry : 8'h80;
      o_matte_y      <= lm;
      o_matte_c      <= (i_legal_range && matte_c_raw > `VKPC_CHROMA_MAX) ?
                        `VKPC_CHROMA_MAX : matte_c_raw;
      o_matte_alpha  <= i_matte_opacity;
    end
  end

  chk_white_toggle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_show_white_press |=> show_white != $past(show_white))
    else $error("white view did not toggle");
  chk_clip_below: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_split_mode && i_key_luma <= i_clip) |-> key_raw == 8'h00)
    else $error("luma under clip cut a hole");
  chk_split_fg: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_split_mode && i_key_luma > i_clip) |-> key_raw == 8'hFF)
    else $error("split fg not full");
  chk_edge_legal: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    edge_mode <= 3'h4)
    else $error("illegal edge mode");
  chk_surr_width: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (edge_mode == vkpc_pkg::VKPC_EDGE_SURROUND) |=> ##1
    (edge_w <= 6'h03 || edge_mode != vkpc_pkg::VKPC_EDGE_SURROUND))
    else $error("surround width over three");
  chk_shadow_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    edge_h <= 6'h06 && edge_w <= 6'h3C && edge_w >= 6'h01)
    else $error("edge size out of range");
  chk_pattern_onehot: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $onehot(pat_sel))
    else $error("pattern select not one-hot");
  chk_center_pos: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_center_press |=> last_x == 8'h80 && last_y == 8'h80)
    else $error("centre not restored");
  chk_edge_balance_enable_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !soft_en |=> o_edge_balance_enable_eff == 8'h80)
    else $error("symmetry active without diffusion");
  chk_undo_restore: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_undo_press && undo_ok) |=> cur_word == $past(undo_word))
    else $error("undo did not restore");
  cov_store: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    store_armed && |i_slot_press);
  cov_undo: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_undo_press && undo_ok);
  cov_stall: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_pix_ready);
  cov_alt: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    alt_en && i_wipe_done);
endmodule
`default_nettype wire

// ===== bench/vkpc_panel.sv
// Purpose : operator panel model issuing one-cycle button pulses
// Assumes : pulses change just after a rising edge of i_clk
// Notes   : btn bits 0 store,1 undo,2 other,3 centre,4 pos,5 normal,
//           6 alt,7 wipe done,8 edge strobe,9 reverse,10 border,
//           11 soft,12 edge_balance_enable,13 polarity
`default_nettype none
module vkpc_panel (
  input  wire logic  i_clk,   // clock
  output logic       o_white, // white-fill view button
  output logic [9:0] o_pat,   // pattern buttons
  output logic [3:0] o_slot,  // slot buttons
  output logic [13:0] o_btn   // other buttons
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_white, o_pat, o_slot, o_btn} = '0;
  // one button at a time, so selectors stay one-hot
  task automatic tap(input int k, input int n);
    @(posedge i_clk);
    o_white <= (k == 0);
    o_pat <= (k == 1) ? 10'h001 << n : 10'h000;
    o_slot <= (k == 2) ? 4'h1 << n : 4'h0;
    o_btn <= (k == 3) ? 14'h0001 << n : 14'h0000;
    @(posedge i_clk);
    {o_white, o_pat, o_slot, o_btn} <= '0;
  endtask
endmodule
`default_nettype wire

// ===== bench/vkpc_keyer_test.sv
// Purpose : self-checking bench of the keyer and pattern control
// Assumes : status is valid three edges after a button
// Notes   : pattern region inputs are held low; key memory is enabled from the recall test to the end of the run
`default_nettype none
module vkpc_keyer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst_n, i_split_mode, i_shadow_left, i_key_mem_en;
  logic i_xpt_strobe, i_legal_range, i_pix_valid, i_pix_ready;
  logic i_pat_white, i_edge_px, i_show_white_press;
  logic i_store_press, i_undo_press, i_other_press, i_center_press;
  logic i_pos_toggle, i_dir_normal, i_alt_toggle, i_wipe_done;
  logic i_edge_sel_strobe, i_dir_reverse, i_border_toggle;
  logic i_soft_toggle, i_edge_balance_enable, i_polarity_toggle;
  logic [7:0] i_opacity, i_clip, i_gain, i_matte_hue, i_matte_saturation;
  logic [7:0] i_matte_brightness, i_matte_opacity, i_border_width;
  logic [7:0] i_softness, i_symmetry, i_key_luma, i_fill, i_bkgd;
  logic signed [7:0] i_move_x, i_move_y;
  logic [2:0] i_edge_sel, o_edge_mode;
  logic [5:0] i_edge_h, i_edge_w, o_edge_h_eff, o_edge_w_eff;
  logic [3:0] i_xpt, i_slot_press;
  logic [9:0] i_pattern_press, o_pattern_sel;
  logic [13:0] btn;
  logic o_pix_ready, o_pix_valid, o_show_white, o_pos_en, o_wipe_reverse;
  logic [7:0] o_pix, o_pos_x, o_pos_y, o_border_w_eff, o_soft_eff;
  logic [7:0] o_edge_balance_enable_eff, o_matte_y, o_matte_c, o_matte_alpha;
  int n_mismatch, n_compared, ep, pr, sd, i, m, hw;
  int sl[4];
  int q[$];
  bit uok, arm, rnd, src, dr, full;
  int sq[28] = '{1,3, 3,0, 2,0, 1,5, 2,0, 3,1, 2,0, 3,2, 3,1, 1,9, 3,0,
                 2,3, 1,2, 2,3};
  assign {i_polarity_toggle, i_edge_balance_enable, i_soft_toggle,
          i_border_toggle, i_dir_reverse, i_edge_sel_strobe, i_wipe_done,
          i_alt_toggle, i_dir_normal, i_pos_toggle, i_center_press,
          i_other_press, i_undo_press, i_store_press} = btn;
  vkpc_keyer vkpc_keyer_i (.*);
  vkpc_panel vkpc_panel_i (.i_clk(i_clk), .o_white(i_show_white_press),
    .o_pat(i_pattern_press), .o_slot(i_slot_press), .o_btn(btn));
  initial {i_clk, i_rst_n, i_split_mode, i_shadow_left, i_key_mem_en,
    i_xpt_strobe, i_legal_range, i_pix_valid, i_pix_ready, i_pat_white,
    i_edge_px, i_opacity, i_clip, i_gain, i_matte_hue, i_matte_saturation,
    i_matte_brightness, i_matte_opacity, i_border_width, i_softness,
    i_symmetry, i_key_luma, i_fill, i_bkgd, i_move_x, i_move_y,
    i_edge_sel, i_edge_h, i_edge_w, i_xpt} = '0;
  always #20 i_clk = ~i_clk;
  task automatic chk(input string nm, input logic [9:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic w;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  // press a button and track the expected pattern selection
  task automatic press(input int k, input int n);
    vkpc_panel_i.tap(k, n);
    if (k == 1) ep = n;
    if (k == 2) begin
      pr = ep;
      if (arm) sl[n] = ep;
      else ep = sl[n];
    end
    if (k == 3 && n == 1 && uok) ep = pr;
    uok = (k == 2);
    arm = (k == 3 && n == 0);
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge i_clk) if (rnd) begin
    {i_matte_hue, i_matte_saturation, i_matte_brightness} <= 24'($urandom);
    {i_matte_opacity, i_gain, i_opacity} <= 24'($urandom);
    {i_border_width, i_softness, i_symmetry} <= 24'($urandom);
    {i_shadow_left, i_split_mode} <= 2'($urandom);
  end
  always @(posedge i_clk) begin
    if (i_pix_valid && o_pix_ready) q.push_back(i_bkgd);
    if (!o_pix_ready) full = 1'h1;
    if (!i_pix_valid || o_pix_ready) begin
      i_pix_valid <= src;
      i_key_luma <= 8'($urandom % 255);
      {i_fill, i_bkgd} <= 16'($urandom);
    end
  end
  always @(posedge i_clk) begin
    if (o_pix_valid && i_pix_ready)
      chk("pixel", o_pix, q.pop_front());
    i_pix_ready <= dr || ($urandom % 4 == 0);
  end
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    sd = $urandom(32'h866F);
    rnd = 1'h1;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'h1;
    w();
    chk("edge_balance_enable", o_edge_balance_enable_eff, 8'h80);
    chk("soft", o_soft_eff, 8'h00);
    chk("border", o_border_w_eff, 8'h00);
    for (i = 0; i < 2; i++) begin
      press(0, 0);
      w();
      chk("white", o_show_white, i == 0);
    end
    for (i = 0; i < 24; i++) begin
      if (i < 10) press(1, i);
      else press(sq[2*i-20], sq[2*i-19]);
      w();
      chk("pattern", o_pattern_sel, 10'h001 << ep);
    end
    for (m = 0; m < 10; m++) begin
      hw = (m % 2) ? 63 : 0;
      @(posedge i_clk);
      {i_edge_sel, i_edge_h, i_edge_w} <= {3'(m / 2), 6'(hw), 6'(hw)};
      press(3, 8);
      w();
      chk("edge", o_edge_mode, m / 2);
      chk("h", o_edge_h_eff, hw ? (m / 2 % 3 == 1 ? 3 : 6) : 1);
      chk("w", o_edge_w_eff, hw ? (m / 2 % 3 == 1 ? 3 : 60) : 1);
    end
    // outline 3/3 is kept for xpt 0, shadow set on xpt 5, then 0 recalled
    @(posedge i_clk);
    {i_key_mem_en, i_xpt_strobe, i_xpt} <= 6'h20;
    @(posedge i_clk);
    {i_key_mem_en, i_xpt_strobe, i_xpt} <= 6'h15;
    @(posedge i_clk);
    {i_key_mem_en, i_xpt_strobe, i_xpt, i_edge_sel} <= 9'h12A;
    press(3, 8);
    w();
    chk("shadow", o_edge_mode, 2);
    @(posedge i_clk);
    {i_xpt_strobe, i_xpt} <= 5'h10;
    @(posedge i_clk);
    i_xpt_strobe <= 1'h0;
    w();
    chk("recall", o_edge_mode, 4);
    chk("recall h", o_edge_h_eff, 3);
    rnd = 1'h0;
    press(3, 4);
    @(posedge i_clk);
    {i_move_x, i_move_y} <= {8'sh05, 8'sh05};
    repeat (4) @(posedge i_clk);
    {i_move_x, i_move_y} <= 16'h0000;
    w();
    chk("moved", o_pos_x > 8'h80 && o_pos_en, 1'h1);
    press(3, 3);
    w();
    chk("cx", o_pos_x, 8'h80);
    chk("cy", o_pos_y, 8'h80);
    press(3, 4);
    w();
    chk("pos", o_pos_en, 1'h0);
    chk("alpha", o_matte_alpha, i_matte_opacity);
    press(3, 9);
    press(3, 6);
    for (i = 0; i < 4; i++) begin
      w();
      chk("dir", o_wipe_reverse, i % 2 == 0);
      press(3, 7);
    end
    press(3, 5);
    w();
    chk("dir", o_wipe_reverse, 1'h0);
    @(posedge i_clk);
    {i_symmetry, i_border_width} <= 16'h2033;
    for (i = 10; i < 14; i++) press(3, i);
    w();
    chk("edge_balance_enable", o_edge_balance_enable_eff, 8'h20);
    chk("border", o_border_w_eff, 8'h33);
    press(3, 11);
    w();
    chk("edge_balance_enable", o_edge_balance_enable_eff, 8'h80);
    rnd = 1'h1;
    @(posedge i_clk);
    i_legal_range <= 1'h1;
    w();
    repeat (30) begin
      @(posedge i_clk);
      #1;
      chk("legal", o_matte_y >= 8'h10 && o_matte_y <= 8'hEB
          && o_matte_c <= 8'hC0, 1'h1);
    end
    rnd = 1'h0;
    @(posedge i_clk);
    {i_split_mode, i_clip} <= 9'h0FF;
    src = 1'h1;
    repeat (200) @(posedge i_clk);
    src = 1'h0;
    dr = 1'h1;
    repeat (20) @(posedge i_clk);
    chk("drained", q.size() == 0 && full, 1'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
